// ===== hw/mode_access_pkg.sv
/*
  mode_access_pkg: shared types and constants for the cpu mode access control block.
  assumes the core presents one access request per cycle with a mode and region decode.
*/
package mode_access_pkg;

  // ------------------------------------------------------------
  // cpu modes and operations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_BOOT     = 3'h0,
    MODE_TEST     = 3'h1,
    MODE_CL_OS    = 3'h3,
    MODE_SYSTEM   = 3'h2,
    MODE_USER     = 3'h6
  } cpu_mode_t;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_EXEC  = 2'h3
  } op_t;

  typedef enum logic [1:0] {
    TGT_ROM = 2'h0,
    TGT_NVM = 2'h1,
    TGT_RAM = 2'h2,
    TGT_REG = 2'h3
  } target_t;

  // ------------------------------------------------------------
  // register groups
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RG_SEGMENT  = 3'h0,
    RG_SYSMGMT  = 3'h1,
    RG_FIREWALL = 3'h2,
    RG_CL_OS    = 3'h3,
    RG_TEST     = 3'h4,
    RG_HW       = 3'h5,
    RG_CPU      = 3'h6
  } reg_group_t;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 8;
  localparam int SEG_COUNT  = 64;
  localparam int HW_COMPS   = 8;
  localparam logic [DATA_W-1:0] DENIED_READ_VALUE = 8'h00;
  localparam logic [2:0] SEG_RIGHTS_RESET = 3'h0;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    op_t        op;
    target_t    target;
    logic [ADDR_W-1:0] addr;
    reg_group_t group;
    logic [2:0] hw_comp;
    logic [DATA_W-1:0] wdata;
  } access_req_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    target_t    target;
    logic [ADDR_W-1:0] phys_addr;
    logic [DATA_W-1:0] wdata;
  } target_req_t;

  typedef struct packed {
    logic       r;
    logic       w;
    logic       x;
    logic [ADDR_W-1:0] first;
    logic [ADDR_W-1:0] last;
    logic [ADDR_W-1:0] offset;
  } segment_t;

  typedef struct packed {
    logic [ADDR_W-1:0] rom_test_top;
    logic [ADDR_W-1:0] nvm_res_top;
    logic [ADDR_W-1:0] ram_res_top;
  } partition_t;

endpackage : mode_access_pkg

// ===== hw/cpu_mode_access_control.sv
/*
  cpu_mode_access_control: checks every core access against the cpu mode, partitions,
  segment table and firewall before forwarding it to memory or register targets.
  assumes the core holds each request stable for its one cycle and consumes the answer
  one cycle later; segment table loads through seg_load_i, firewall through register writes.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - isolate firmware from applications by partitions plus privilege modes
// - access management and hardware configuration only in system mode; test mode has both too, boot mode hardware registers
// - user applications reach only memory granted by their segments
// - hardware component registers need an explicit grant bit
// - with that mode suppressed, vectored system calls leave the mode unchanged
// - restricted configuration gives system and user modes all of ram
// - restricted configuration keeps firewall writable but without effect
// - full configuration follows emulation option; restricted has fixed reserved nvm
// - full configuration firewall isolates os ram except one shared window
// - rom split test/application, nvm and ram split reserved/application
// - segments only map into application regions; table lives in physical memory (here held in internal registers loaded through seg_load_i)
// - denied register read returns zero, denied write is dropped
// - up to 64 segments with rights, first, last and relocation offset
module cpu_mode_access_control
  import mode_access_pkg::*;
#(
  parameter int        SEGMENTS   = SEG_COUNT,
  parameter bit        FULL_CONFIG = 1'b1,
  parameter logic [ADDR_W-1:0] ROM_TEST_TOP = 16'h1000,
  parameter logic [ADDR_W-1:0] NVM_RES_TOP  = 16'h0400,
  parameter logic [ADDR_W-1:0] NVM_RES_EMU  = 16'h1000,
  parameter logic [ADDR_W-1:0] RAM_RES_TOP  = 16'h0100,
  parameter logic [ADDR_W-1:0] RAM_RES_EMU  = 16'h0400
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              emulation_option_i,
  input  wire logic              mode_set_i,
  input  wire cpu_mode_t         mode_new_i,
  input  wire logic              vectored_system_call_i,
  input  wire logic              call_return_i,
  input  wire logic              seg_load_i,
  input  wire logic [5:0]        seg_index_i,
  input  wire segment_t          seg_data_i,
  input  wire logic [HW_COMPS-1:0] seg_hw_grant_i,
  input  wire access_req_t       req_i,
  input  wire logic [DATA_W-1:0] reg_rdata_i,
  output logic                   full_configuration_o,
  output cpu_mode_t              mode_o,
  output target_req_t            target_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   denied_o
);

  initial begin
    if (SEGMENTS < 1 || SEGMENTS > SEG_COUNT)
      $error("SEGMENTS must lie between 1 and 64");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cpu_mode_t mode_q, mode_d, saved_mode_q;
  segment_t  seg_q [SEGMENTS];
  logic [HW_COMPS-1:0] seg_hw_q [SEGMENTS];
  logic [ADDR_W-1:0] fw_base_q, fw_size_q;
  logic [HW_COMPS-1:0] fw_hw_q;
  target_req_t target_q;
  logic [DATA_W-1:0] rdata_q;
  logic denied_q, rd_pend_q;

  // ------------------------------------------------------------
  // partition decode
  // ------------------------------------------------------------
  wire logic cl_os_allowed = FULL_CONFIG;
  wire logic [ADDR_W-1:0] nvm_top =
    (FULL_CONFIG && emulation_option_i) ? NVM_RES_EMU : NVM_RES_TOP;
  wire logic [ADDR_W-1:0] ram_top =
    (FULL_CONFIG && emulation_option_i) ? RAM_RES_EMU : RAM_RES_TOP;

  function automatic logic in_reserved(target_t t, logic [ADDR_W-1:0] a,
                                       logic [ADDR_W-1:0] nt, logic [ADDR_W-1:0] rt);
    case (t)
      TGT_ROM: in_reserved = a < ROM_TEST_TOP;
      TGT_NVM: in_reserved = a < nt;
      TGT_RAM: in_reserved = a < rt;
      default: in_reserved = 1'b0;
    endcase
  endfunction : in_reserved

  wire logic req_reserved = in_reserved(req_i.target, req_i.addr, nvm_top, ram_top);
  wire logic is_mem = req_i.target != TGT_REG;
  wire logic op_ok_rom = req_i.op != OP_WRITE;
  wire logic op_ok_ram = req_i.op != OP_EXEC;
  wire logic op_ok = (req_i.target == TGT_ROM) ? op_ok_rom :
                     (req_i.target == TGT_RAM) ? op_ok_ram : 1'b1;

  // ------------------------------------------------------------
  // segment lookup, user mode
  // ------------------------------------------------------------
  logic seg_hit;
  logic [ADDR_W-1:0] seg_phys;
  logic [HW_COMPS-1:0] seg_hw_any;
  always_comb begin
    seg_hit    = 1'b0;
    seg_phys   = req_i.addr;
    seg_hw_any = '0;
    for (int i = 0; i < SEGMENTS; i++) begin
      if (!seg_hit && req_i.addr >= seg_q[i].first && req_i.addr <= seg_q[i].last &&
          ((req_i.op == OP_READ && seg_q[i].r) || (req_i.op == OP_WRITE && seg_q[i].w) ||
           (req_i.op == OP_EXEC && seg_q[i].x))) begin
        seg_hit  = 1'b1;
        seg_phys = req_i.addr + seg_q[i].offset;
      end
      if (seg_q[i].r || seg_q[i].w || seg_q[i].x) begin
        seg_hw_any = seg_hw_any | seg_hw_q[i];
      end
    end
  end

  // relocated address must still fall in the application region
  wire logic seg_phys_app = !in_reserved(req_i.target, seg_phys, nvm_top, ram_top);

  wire logic fw_window = (req_i.addr >= fw_base_q) &&
                         ({1'b0, req_i.addr} < {1'b0, fw_base_q} + {1'b0, fw_size_q});

  // ------------------------------------------------------------
  // memory permission per mode
  // ------------------------------------------------------------
  logic mem_ok;
  always_comb begin
    mem_ok = 1'b0;
    case (mode_q)
      MODE_TEST:   mem_ok = op_ok;
      MODE_BOOT,
      MODE_CL_OS:  mem_ok = op_ok && (req_reserved ||
                     (FULL_CONFIG && req_i.target == TGT_RAM && fw_window));
      MODE_SYSTEM: mem_ok = op_ok && (!req_reserved ||
                     (!FULL_CONFIG && req_i.target == TGT_RAM));
      MODE_USER:   mem_ok = op_ok && ((!FULL_CONFIG && req_i.target == TGT_RAM) ||
                     (!req_reserved && seg_hit && seg_phys_app));
      default:     mem_ok = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // register permission per group
  // ------------------------------------------------------------
  wire logic sys_like = (mode_q == MODE_SYSTEM) || (mode_q == MODE_TEST);
  logic reg_ok;
  always_comb begin
    reg_ok = 1'b0;
    case (req_i.group)
      RG_SEGMENT,
      RG_SYSMGMT,
      RG_FIREWALL: reg_ok = sys_like;
      RG_CL_OS:    reg_ok = (mode_q == MODE_CL_OS) || (mode_q == MODE_BOOT) ||
                            (mode_q == MODE_TEST);
      RG_TEST:     reg_ok = mode_q == MODE_TEST;
      RG_HW:       reg_ok = sys_like || (mode_q == MODE_BOOT) ||
                            (mode_q == MODE_USER && seg_hw_any[req_i.hw_comp]) ||
                            (mode_q == MODE_CL_OS && fw_hw_q[req_i.hw_comp]);
      RG_CPU:      reg_ok = 1'b1;
      default:     reg_ok = 1'b0;
    endcase
  end

  wire logic granted = is_mem ? mem_ok : reg_ok;
  wire logic fw_write = req_i.valid && granted && req_i.target == TGT_REG &&
                        req_i.group == RG_FIREWALL && req_i.op == OP_WRITE;
  wire logic [1:0] fw_sel = req_i.addr[1:0];

  // ------------------------------------------------------------
  // mode transitions
  // ------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    if (vectored_system_call_i && cl_os_allowed &&
        (mode_q == MODE_SYSTEM || mode_q == MODE_USER)) begin
      mode_d = MODE_CL_OS;
    end else if (call_return_i && mode_q == MODE_CL_OS) begin
      mode_d = saved_mode_q;
    end else if (mode_set_i && (sys_like || mode_q == MODE_BOOT)) begin
      // boot firmware hands over; else only privileged code picks a mode
      // the suppressed mode is never reachable
      mode_d = (mode_new_i == MODE_CL_OS && !cl_os_allowed) ? mode_q : mode_new_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q       <= MODE_BOOT;
      saved_mode_q <= MODE_SYSTEM;
    end else begin
      mode_q <= mode_d;
      if (mode_d == MODE_CL_OS && mode_q != MODE_CL_OS) begin
        saved_mode_q <= mode_q;
      end
    end
  end

  // ------------------------------------------------------------
  // segment table, loaded only in privileged modes
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < SEGMENTS; i++) begin
        seg_q[i]    <= '0;
        seg_hw_q[i] <= '0;
      end
    end else if (seg_load_i && sys_like && 32'(seg_index_i) < SEGMENTS) begin
      seg_q[seg_index_i]    <= seg_data_i;
      seg_hw_q[seg_index_i] <= seg_hw_grant_i;
    end
  end

  // ------------------------------------------------------------
  // firewall registers, writable in both configurations
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fw_base_q <= '0;
      fw_size_q <= '0;
      fw_hw_q   <= '0;
    end else if (fw_write) begin
      case (fw_sel)
        2'h0:    fw_base_q <= {fw_base_q[ADDR_W-1:DATA_W], req_i.wdata};
        2'h1:    fw_base_q <= {req_i.wdata, fw_base_q[DATA_W-1:0]};
        2'h2:    fw_size_q <= {fw_size_q[ADDR_W-1:DATA_W], req_i.wdata};
        default: fw_hw_q   <= req_i.wdata;
      endcase
    end
  end

  // ------------------------------------------------------------
  // forwarding and answers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      target_q  <= '0;
      denied_q  <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      // a denied access never reaches the target, so no state changes
      target_q.valid     <= req_i.valid && granted;
      target_q.write     <= req_i.op == OP_WRITE;
      target_q.target    <= req_i.target;
      target_q.phys_addr <= (mode_q == MODE_USER && is_mem) ? seg_phys : req_i.addr;
      target_q.wdata     <= req_i.wdata;
      denied_q           <= req_i.valid && !granted;
      rd_pend_q          <= req_i.valid && granted && req_i.op != OP_WRITE;
    end
  end

  // register data returns one cycle after forwarding; denied reads give zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= DENIED_READ_VALUE;
    end else begin
      rdata_q <= rd_pend_q ? reg_rdata_i : DENIED_READ_VALUE;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      full_configuration_o <= 1'b0;
    end else begin
      full_configuration_o <= FULL_CONFIG;
    end
  end

  assign mode_o   = mode_q;
  assign target_o = target_q;
  assign rdata_o  = rdata_q;
  assign denied_o = denied_q;

endmodule : cpu_mode_access_control

`default_nettype wire

// ===== testbench/cpu_mode_access_control_chk.sv
/* port checker for the access control block.
   assumes a bind onto every instance; sees ports only. */
`timescale 1ns/1ps
`default_nettype none
module cpu_mode_access_control_chk
  import mode_access_pkg::*;
#(
  parameter bit FULL_CONFIG = 1'b1
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              mode_set_i,
  input wire logic              vectored_system_call_i,
  input wire access_req_t       req_i,
  input wire logic [DATA_W-1:0] reg_rdata_i,
  input wire logic              full_configuration_o,
  input wire cpu_mode_t         mode_o,
  input wire target_req_t       target_o,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              denied_o
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_answer_exactly_one: assert property (req_i.valid |=> target_o.valid != denied_o)
    else $error("request not answered once");
  a_no_idle_answer: assert property (!req_i.valid |=> !target_o.valid && !denied_o)
    else $error("answer without request");
  a_denied_reads_zero: assert property (denied_o |=> rdata_o == DENIED_READ_VALUE)
    else $error("denied access returned data");
  a_read_data_path: assert property (target_o.valid && !target_o.write
    |=> rdata_o == $past(reg_rdata_i))
    else $error("read data not passed on");
  a_write_no_data: assert property (target_o.valid && target_o.write |=> rdata_o == 8'h00)
    else $error("write returned data");
  a_no_os_mode: assert property (!FULL_CONFIG |-> mode_o != MODE_CL_OS)
    else $error("os mode in restricted build");
  a_vec_call_plain: assert property (!FULL_CONFIG && vectored_system_call_i && !mode_set_i
    |=> $stable(mode_o))
    else $error("vectored call changed mode");
  a_user_mode_locked: assert property (mode_o == MODE_USER && !vectored_system_call_i
    |=> mode_o == MODE_USER)
    else $error("user mode left without call");
  a_config_flag: assert property (!$past(rst_i) |-> full_configuration_o == FULL_CONFIG)
    else $error("configuration flag wrong");

  c_denied: cover property (denied_o);
  c_read: cover property (target_o.valid && !target_o.write);
  c_user: cover property (mode_o == MODE_USER);
endmodule : cpu_mode_access_control_chk

bind cpu_mode_access_control cpu_mode_access_control_chk #(.FULL_CONFIG(FULL_CONFIG)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .mode_set_i(mode_set_i),
  .vectored_system_call_i(vectored_system_call_i), .req_i(req_i),
  .reg_rdata_i(reg_rdata_i), .full_configuration_o(full_configuration_o),
  .mode_o(mode_o), .target_o(target_o), .rdata_o(rdata_o), .denied_o(denied_o));
`default_nettype wire

// ===== testbench/target_model.sv
/* memory and register side model answering forwarded accesses.
   assumes read data is taken in the cycle target valid stands. */
`timescale 1ns/1ps
`default_nettype none
module target_model
  import mode_access_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire target_req_t       target_i,
  output logic [DATA_W-1:0]      rdata_o
);
  // ------------------------------------------------------------
  // answer
  // ------------------------------------------------------------
  logic [DATA_W-1:0] idle_q;
  logic              read_w;
  // churning idle value so stale data never passes for a match
  assign read_w  = target_i.valid && !target_i.write;
  assign rdata_o = read_w ? (target_i.phys_addr[7:0] ^ 8'h5A) : idle_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_q <= 8'hA5;
    end else begin
      idle_q <= idle_q + 8'h3B;
    end
  end
endmodule : target_model
`default_nettype wire

// ===== testbench/tb_cpu_mode_access_control.sv
/* testbench: restricted and full builds side by side, same stimulus.
   assumes target_model answers reads of the restricted build. */
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_mode_access_control;
  import mode_access_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, set_i = 1'b0, vec_i = 1'b0, ret_i = 1'b0, load_i = 1'b0;
  cpu_mode_t   new_i = MODE_BOOT;
  segment_t    seg_i = '0;
  access_req_t req_i = '0;
  logic [7:0]  rd_i;
  logic        emu_i = 1'b0;
  logic [5:0]  idx_i = 6'h00;
  logic [7:0]  grant_i = 8'h00;
  logic [2:0]  comp_i = 3'h2;
  logic        fc_r, fc_f, n_r, n_f;
  cpu_mode_t   m_r, m_f;
  target_req_t t_r, t_f;
  logic [7:0]  d_r, d_f;
  int          mismatches = 0;
  int          num_checks = 0;

  always #25 clk_i = ~clk_i;

  cpu_mode_access_control #(.FULL_CONFIG(1'b0)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .emulation_option_i(emu_i), .mode_set_i(set_i), .mode_new_i(new_i),
    .vectored_system_call_i(vec_i), .call_return_i(ret_i), .seg_load_i(load_i),
    .seg_index_i(idx_i), .seg_data_i(seg_i), .seg_hw_grant_i(grant_i), .req_i(req_i),
    .reg_rdata_i(rd_i), .full_configuration_o(fc_r), .mode_o(m_r), .target_o(t_r),
    .rdata_o(d_r), .denied_o(n_r));
  cpu_mode_access_control #(.FULL_CONFIG(1'b1)) u_dut_full (.clk_i(clk_i), .rst_i(rst_i),
    .emulation_option_i(emu_i), .mode_set_i(set_i), .mode_new_i(new_i),
    .vectored_system_call_i(vec_i), .call_return_i(ret_i), .seg_load_i(load_i),
    .seg_index_i(idx_i), .seg_data_i(seg_i), .seg_hw_grant_i(grant_i), .req_i(req_i),
    .reg_rdata_i(rd_i), .full_configuration_o(fc_f), .mode_o(m_f), .target_o(t_f),
    .rdata_o(d_f), .denied_o(n_f));
  target_model u_target (.clk_i(clk_i), .rst_i(rst_i), .target_i(t_r), .rdata_o(rd_i));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic tick();
    @(posedge clk_i);
    #2;
  endtask : tick

  task automatic set_mode(input cpu_mode_t m);
    set_i = 1'b1;
    new_i = m;
    tick();
    set_i = 1'b0;
  endtask : set_mode

  // one access; judges both builds, then the restricted read data
  task automatic access(input op_t op, input target_t tg, input logic [15:0] a,
      input reg_group_t g, input logic ok_r, input logic ok_f, input logic [15:0] pa);
    req_i = '{valid:1'b1, op:op, target:tg, addr:a, group:g, hw_comp:comp_i, wdata:8'hC3};
    tick();
    req_i.valid = 1'b0;
    check(t_r.valid, ok_r);
    check(n_r, !ok_r);
    check(t_f.valid, ok_f);
    if (ok_r) check(t_r.phys_addr, pa);
    tick();
    check(d_r, (ok_r && op != OP_WRITE) ? (pa[7:0] ^ 8'h5A) : 8'h00);
  endtask : access

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check(m_r, MODE_BOOT);
    check(fc_f, 1'b0);
    rst_i = 1'b0;
    tick();
    check(fc_f, 1'b1);
    check(fc_r, 1'b0);
  endtask : t_reset

  task automatic t_system();
    set_mode(MODE_SYSTEM);
    check(m_r, MODE_SYSTEM);
    access(OP_READ, TGT_RAM, 16'h0210, RG_CPU, 1'b1, 1'b1, 16'h0210);
    access(OP_READ, TGT_RAM, 16'h0010, RG_CPU, 1'b1, 1'b0, 16'h0010);
    // emulation widens the reserved ram of the full build only
    emu_i = 1'b1;
    access(OP_READ, TGT_RAM, 16'h0210, RG_CPU, 1'b1, 1'b0, 16'h0210);
    emu_i = 1'b0;
    access(OP_WRITE, TGT_REG, 16'h0001, RG_FIREWALL, 1'b1, 1'b1, 16'h0001);
    access(OP_READ, TGT_RAM, 16'h0010, RG_CPU, 1'b1, 1'b0, 16'h0010);
  endtask : t_system

  task automatic t_user();
    // read only segment, relocated by one page into application nvm
    seg_i = '{r:1'b1, w:1'b0, x:1'b0, first:16'h0800, last:16'h08FF, offset:16'h0100};
    idx_i   = 6'h05;
    grant_i = 8'h04;
    load_i  = 1'b1;
    tick();
    load_i  = 1'b0;
    set_mode(MODE_USER);
    check(m_r, MODE_USER);
    access(OP_READ, TGT_NVM, 16'h0810, RG_CPU, 1'b1, 1'b1, 16'h0910);
    access(OP_READ, TGT_NVM, 16'h0A00, RG_CPU, 1'b0, 1'b0, 16'h0000);
    access(OP_WRITE, TGT_NVM, 16'h0810, RG_CPU, 1'b0, 1'b0, 16'h0000);
    access(OP_READ, TGT_REG, 16'h0002, RG_HW, 1'b1, 1'b1, 16'h0002);
    comp_i = 3'h3;
    access(OP_READ, TGT_REG, 16'h0002, RG_HW, 1'b0, 1'b0, 16'h0000);
    access(OP_WRITE, TGT_REG, 16'h0000, RG_SEGMENT, 1'b0, 1'b0, 16'h0000);
    set_mode(MODE_SYSTEM);
    check(m_r, MODE_USER);
  endtask : t_user

  task automatic t_vector();
    vec_i = 1'b1;
    tick();
    vec_i = 1'b0;
    check(m_r, MODE_USER);
    check(m_f, MODE_CL_OS);
    ret_i = 1'b1;
    tick();
    ret_i = 1'b0;
    check(m_f, MODE_USER);
  endtask : t_vector

  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    #2;
    t_reset();
    tick();
    t_system();
    t_user();
    t_vector();
    wrap_up();
  end

  // the whole run needs well under a hundred cycles
  initial begin
    repeat (2000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end
endmodule : tb_cpu_mode_access_control
`default_nettype wire
